// >>> verilog/pic_pkg.sv
// What this block does
// [R01] All counting runs from the one system clock domain.
// [R02] Sixteen-bit counter advances once per divided tick and wraps.
// [R03] Tick comes from dividing the system clock by six.
// [R04] Selected input edge copies the counter into the capture latch.
// [R05] Every latch pulse sets the capture flag; a read of address 00 latches the counter without setting it.
// [R06] Accessing the capture high byte clears the capture flag.
// [R07] Capture flag can raise an interrupt and shows in input status.
// [R08] Reader input level is readable in line status at any time.
// [R09] Capture low byte at address 02, high byte at address 03.
// [R10] Control register holds rate, power switch, method bits and source.
// [R11] Software starts with rate 0110 and other control bits clear.
// [R12] Methods 01 or 10 for interval, 11 for pulse width.
// [R13] Software counts overflow events for intervals beyond the wrap.
// [R14] Power switch bit drives the reader supply output.
// [R15] Software uses only one of reader, timer and cassette at once.
// [R16] Counter overflow sets the overflow flag and requests an interrupt.
// [R17] Reading address 00 latches the counter and returns its low byte.
// [R18] Source select clear takes latch pulses from the cassette input.
`default_nettype none
package pic_pkg;
   localparam logic [7:0] PIC_ADDR_CNT_LO = 8'h00;
   localparam logic [7:0] PIC_ADDR_CNT_HI = 8'h01;
   localparam logic [7:0] PIC_ADDR_CAP_LO = 8'h02;
   localparam logic [7:0] PIC_ADDR_CAP_HI = 8'h03;
   localparam logic [7:0] PIC_ADDR_ISTAT = 8'h04;
   localparam logic [7:0] PIC_ADDR_LSTAT = 8'h05;
   localparam logic [7:0] PIC_ADDR_CTRL = 8'h06;
   // Control field positions
   localparam int PIC_CTRL_SRC = 0;
   localparam int PIC_CTRL_M0 = 1;
   localparam int PIC_CTRL_M1 = 2;
   localparam int PIC_CTRL_PWR = 3;
   localparam int PIC_CTRL_RATE_LO = 4;
   // Status bit positions
   localparam int PIC_IST_OVF = 0;
   localparam int PIC_IST_CAP = 2;
   localparam int PIC_LST_RDR = 0;
   localparam int PIC_LST_CAS = 1;
   localparam logic [7:0] PIC_CTRL_RST = 8'h00;
   localparam real PIC_SYS_MHZ = 3.6864;
   localparam real PIC_CORE_MHZ = 200.0;
   localparam int PIC_SYS_DIV = 6;
   // Core cycles per system-clock period, rounded down (shortest time)
   localparam int PIC_CORE_PER_SYS = int'($floor(PIC_CORE_MHZ / PIC_SYS_MHZ));
   localparam int PIC_TICK_CYCLES = PIC_CORE_PER_SYS * PIC_SYS_DIV;
   typedef enum logic [1:0] {
      PIC_M_OFF,
      PIC_M_RISE,
      PIC_M_FALL,
      PIC_M_BOTH
   } pic_method_t;
endpackage
`default_nettype wire

// >>> verilog/pic_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pic_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// >>> verilog/pic_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none
module pic_sync_edge (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic pin,
   pic_edge_if.src eo
);
   logic s1_r, s2_r, s3_r;
   logic s1_nxt, s2_nxt, s3_nxt;
   always_comb begin
      s1_nxt = pin;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end
   // Edges look only at synchronised stages
   assign eo.level = s2_r;
   assign eo.rise = s2_r & ~s3_r;
   assign eo.fall = ~s2_r & s3_r;
endmodule // pic_sync_edge
`default_nettype wire

// >>> verilog/pic_capture_top.sv
`timescale 1ns/1ps
`default_nettype none
module pic_capture_top #(
   parameter int TICK_CYCLES = pic_pkg::PIC_TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic reader_data_pin,
   input wire logic cassette_pin,
   output logic reader_power,
   output logic capture_irq,
   output logic overflow_irq
);
   import pic_pkg::*;

   pic_edge_if rdr_e ();
   pic_edge_if cas_e ();

   pic_sync_edge u_rdr (
      .core_clk(core_clk),
      .nrst(nrst),
      .pin(reader_data_pin),
      .eo(rdr_e)
   );
   pic_sync_edge u_cas (
      .core_clk(core_clk),
      .nrst(nrst),
      .pin(cassette_pin),
      .eo(cas_e)
   );

   logic [15:0] cnt_r, cnt_nxt;
   logic [15:0] cap_r, cap_nxt;
   logic [15:0] div_r, div_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic cap_flag_r, cap_flag_nxt;
   logic ovf_flag_r, ovf_flag_nxt;
   logic tick;
   logic ovf_evt;
   logic src_rise, src_fall;
   logic edge_hit;
   logic cpu_latch;
   pic_method_t method;

   // Tick every sixth system-clock period, in core cycles
   assign tick = (div_r == 16'(TICK_CYCLES - 1));
   assign ovf_evt = tick && (cnt_r == 16'hFFFF);

   // [R18] clear picks cassette
   always_comb begin
      if (ctrl_r[PIC_CTRL_SRC]) begin
         src_rise = rdr_e.rise;
         src_fall = rdr_e.fall;
      end else begin
         src_rise = cas_e.rise;
         src_fall = cas_e.fall;
      end
   end

   assign method = pic_method_t'({ctrl_r[PIC_CTRL_M1], ctrl_r[PIC_CTRL_M0]});

   // [R04] edge method select
   always_comb begin
      case (method)
         PIC_M_OFF: edge_hit = 1'b0;
         PIC_M_RISE: edge_hit = src_rise;
         PIC_M_FALL: edge_hit = src_fall;
         PIC_M_BOTH: edge_hit = src_rise | src_fall;
         default: edge_hit = 1'b0;
      endcase
   end

   // [R17] read of address 00 latches counter
   assign cpu_latch = rd && (addr == PIC_ADDR_CNT_LO);

   always_comb begin
      div_nxt = div_r;
      cnt_nxt = cnt_r;
      cap_nxt = cap_r;
      cap_flag_nxt = cap_flag_r;
      ovf_flag_nxt = ovf_flag_r;
      ctrl_nxt = ctrl_r;
      rdata_nxt = 8'h00;
      // [R01] all counting from one clock
      // [R03] divide by six
      if (tick) begin
         div_nxt = 16'h0000;
      end else begin
         div_nxt = div_r + 16'h0001;
      end
      // [R02] counter wraps on tick
      if (tick) begin
         cnt_nxt = cnt_r + 16'h0001;
      end
      // [R06] high byte access clears flag
      if ((rd || wr) && addr == PIC_ADDR_CAP_HI) begin
         cap_flag_nxt = 1'b0;
      end
      // Input status write of zero to bit clears overflow flag
      // [R16] software clears overflow
      if (wr && addr == PIC_ADDR_ISTAT && !wdata[PIC_IST_OVF]) begin
         ovf_flag_nxt = 1'b0;
      end
      // [R16] overflow sets, winning over clear
      if (ovf_evt) begin
         ovf_flag_nxt = 1'b1;
      end
      // [R04] edge copies counter
      // [R05] latch sets flag, set wins
      if (edge_hit) begin
         cap_nxt = cnt_r;
         cap_flag_nxt = 1'b1;
      end
      // CPU latch takes priority for the value; flag only for edges
      if (cpu_latch) begin
         cap_nxt = cnt_r;
      end
      // [R10] control register write
      if (wr && addr == PIC_ADDR_CTRL) begin
         ctrl_nxt = wdata;
      end
      if (rd) begin
         case (addr)
            // [R17] low counter byte returned
            PIC_ADDR_CNT_LO: rdata_nxt = cnt_r[7:0];
            PIC_ADDR_CNT_HI: rdata_nxt = cap_r[15:8];
            // [R09] capture bytes low then high
            PIC_ADDR_CAP_LO: rdata_nxt = cap_r[7:0];
            PIC_ADDR_CAP_HI: rdata_nxt = cap_r[15:8];
            // [R07] flag visible for polling
            PIC_ADDR_ISTAT: begin
               rdata_nxt[PIC_IST_CAP] = cap_flag_r;
               rdata_nxt[PIC_IST_OVF] = ovf_flag_r;
            end
            // [R08] live reader level
            PIC_ADDR_LSTAT: begin
               rdata_nxt[PIC_LST_RDR] = rdr_e.level;
               rdata_nxt[PIC_LST_CAS] = cas_e.level;
            end
            PIC_ADDR_CTRL: rdata_nxt = ctrl_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         div_r <= 16'h0000;
         cnt_r <= 16'h0000;
         cap_r <= 16'h0000;
         cap_flag_r <= 1'b0;
         ovf_flag_r <= 1'b0;
         ctrl_r <= PIC_CTRL_RST;
         rdata_r <= 8'h00;
      end else begin
         div_r <= div_nxt;
         cnt_r <= cnt_nxt;
         cap_r <= cap_nxt;
         cap_flag_r <= cap_flag_nxt;
         ovf_flag_r <= ovf_flag_nxt;
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;
   // [R14] supply follows switch bit
   assign reader_power = ctrl_r[PIC_CTRL_PWR];
   // [R07] capture interrupt request
   assign capture_irq = cap_flag_r;
   // [R16] overflow interrupt request
   assign overflow_irq = ovf_flag_r;
endmodule // pic_capture_top
`default_nettype wire

// >>> bench/pic_capture_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pic_chk #(
   parameter int TICK_CYCLES = 1
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic reader_data_pin,
   input wire logic cassette_pin,
   input wire logic reader_power,
   input wire logic capture_irq,
   input wire logic overflow_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_power_follows: assert property (wr && addr == 8'h06 |=> reader_power == $past(wdata[3]))
      else $error("supply output not set by control write");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read answer cycle");
   a_status_bits: assert property (rd && addr == 8'h04 |=>
      rdata[2] == $past(capture_irq) && rdata[0] == $past(overflow_irq))
      else $error("status read does not mirror flags");
   // Pins at the same level as four cycles before, so no fresh edge can win over the clear
   a_high_clears: assert property ((rd || wr) && addr == 8'h03
      && $past(reader_data_pin, 4) == reader_data_pin
      && $past(cassette_pin, 4) == cassette_pin |=> !capture_irq)
      else $error("capture flag kept after high byte access");
   a_line_level: assert property (rd && addr == 8'h05
      && $past(reader_data_pin, 4) == reader_data_pin
      && $past(cassette_pin, 4) == cassette_pin
      |=> rdata[1:0] == {$past(cassette_pin), $past(reader_data_pin)})
      else $error("line status differs from input levels");
   a_unmapped_zero: assert property (rd && addr > 8'h06 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_cap_holds: assert property (capture_irq
      && !((rd || wr) && (addr == 8'h01 || addr == 8'h03)) |=> capture_irq)
      else $error("capture flag dropped without access");
   a_ovf_holds: assert property (overflow_irq && !(wr && addr == 8'h04) |=> overflow_irq)
      else $error("overflow flag dropped without clear");
endmodule // pic_chk
bind pic_capture_top pic_chk #(.TICK_CYCLES(TICK_CYCLES)) pic_chk_i (
   .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .reader_data_pin(reader_data_pin), .cassette_pin(cassette_pin),
   .reader_power(reader_power), .capture_irq(capture_irq), .overflow_irq(overflow_irq));
`default_nettype wire

// >>> bench/pic_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module pic_src_model (
   input wire logic core_clk,
   input wire logic [1:0] flip,
   output logic rdr_pin,
   output logic cas_pin
);
   initial rdr_pin = 1'b0;
   initial cas_pin = 1'b0;
   always @(posedge core_clk) begin
      if (flip[0]) rdr_pin <= ~rdr_pin;
      if (flip[1]) cas_pin <= ~cas_pin;
   end
endmodule // pic_src_model
`default_nettype wire

// >>> bench/tb_pic_capture_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pic_capture_top;
   import pic_pkg::*;
   logic core_clk, nrst, wr, rd, rdr, cas, pwr, cirq, oirq;
   logic [7:0] addr, wdata, rdata, a0, a1;
   logic [1:0] flip;
   int mismatches, checks, cyc;
   // Tick every cycle so a wrap fits the run
   pic_capture_top #(.TICK_CYCLES(1)) pic_capture_top_i (
      .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .reader_data_pin(rdr), .cassette_pin(cas),
      .reader_power(pwr), .capture_irq(cirq), .overflow_irq(oirq));
   pic_src_model pic_src_model_i (.core_clk(core_clk), .flip(flip), .rdr_pin(rdr),
      .cas_pin(cas));
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic pulse(input logic [1:0] f);
      @(posedge core_clk);
      flip <= f;
      @(posedge core_clk);
      flip <= 2'b00;
      repeat (8) @(posedge core_clk);
      #1;
   endtask
   task automatic t_counter;
      rd_reg(PIC_ADDR_CNT_LO, a0);
      rd_reg(PIC_ADDR_CAP_LO, a1);
      chk(a1, a0);
      rd_reg(PIC_ADDR_CNT_HI, a1);
      chk(a1, 8'h00);
      rd_reg(PIC_ADDR_CNT_LO, a1);
      chk(a1 - a0, 8'h06);
      rd_reg(8'h80, a1);
      chk(a1, 8'h00);
   endtask
   task automatic t_power;
      wr_reg(PIC_ADDR_CTRL, 8'h08);
      @(posedge core_clk);
      #1 chk(8'(pwr), 8'h01);
      wr_reg(PIC_ADDR_CTRL, 8'h60);
      @(posedge core_clk);
      #1 chk(8'(pwr), 8'h00);
      rd_reg(PIC_ADDR_CTRL, a0);
      chk(a0, 8'h60);
   endtask
   task automatic t_methods;
      for (int m = 0; m < 4; m++) begin
         wr_reg(PIC_ADDR_CTRL, 8'(m * 2 + 1));
         rd_reg(PIC_ADDR_CAP_HI, a0);
         pulse(2'b01);
         chk(8'(cirq), 8'(m[0]));
         rd_reg(PIC_ADDR_CAP_HI, a0);
         chk(8'(cirq), 8'h00);
         pulse(2'b01);
         chk(8'(cirq), 8'(m[1]));
         rd_reg(PIC_ADDR_CAP_HI, a0);
      end
   endtask
   task automatic t_source;
      wr_reg(PIC_ADDR_CTRL, 8'h06);
      pulse(2'b01);
      chk(8'(cirq), 8'h00);
      pulse(2'b10);
      chk(8'(cirq), 8'h01);
      rd_reg(PIC_ADDR_CAP_LO, a0);
      rd_reg(PIC_ADDR_CNT_LO, a1);
      chk(8'(a1 - a0 > 8'h04 && a1 - a0 < 8'h14), 8'h01);
      rd_reg(PIC_ADDR_LSTAT, a0);
      chk(a0 & 8'h03, 8'h03);
      rd_reg(PIC_ADDR_ISTAT, a0);
      chk(a0 & 8'h04, 8'h04);
      pulse(2'b11);
      rd_reg(PIC_ADDR_LSTAT, a0);
      chk(a0 & 8'h03, 8'h00);
   endtask
   task automatic t_overflow;
      repeat (70000) if (oirq !== 1'b1) @(posedge core_clk);
      rd_reg(PIC_ADDR_ISTAT, a0);
      chk(a0 & 8'h01, 8'h01);
      wr_reg(PIC_ADDR_ISTAT, 8'h00);
      rd_reg(PIC_ADDR_ISTAT, a0);
      chk(a0 & 8'h01, 8'h00);
      // One wrap seen and cleared, so the overflow request must now read low
      chk(8'(oirq), 8'h00);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Hang guard; the wrap wait alone needs about 65536 cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      {nrst, wr, rd, addr, wdata, flip} = '0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      #1 chk(8'({pwr, cirq, oirq}), 8'h00);
      t_counter();
      t_power();
      t_methods();
      t_source();
      t_overflow();
      close_out();
   end
endmodule // tb_pic_capture_top
`default_nettype wire
